// ### design/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// register indices on the plain port (word addresses)
`define PMC_ADDR_CFG      4'h0
`define PMC_ADDR_STATUS   4'h1
`define PMC_ADDR_MASK     4'h2
`define PMC_ADDR_STATE    4'h3
`define PMC_ADDR_ENTER    4'h4

// configuration register fields, and the request bit of the entry register
`define PMC_BIT_DOZE      8
`define PMC_BIT_NAP       9
`define PMC_BIT_SLEEP     10
`define PMC_BIT_GATE_EN   11
`define PMC_CFG_RESET     32'h0000_0000
`define PMC_CFG_WMASK     32'h0000_0F00
`define PMC_BIT_ENTER     0

// status / mask bit positions
`define PMC_EV_EXT        0
`define PMC_EV_SMI        1
`define PMC_EV_DEC        2
`define PMC_EV_PERF       3
`define PMC_EV_THERM      4
`define PMC_EV_REJECT     5
`define PMC_EV_W          6

// quiesce ack must be deasserted this many bus clocks before snooping
`define PMC_SNOOP_CLOCKS  8
`define PMC_ENTRY_CYCLES  4

`endif

// ### design/pmc_pkg.sv
package pmc_pkg;
   typedef enum logic [4:0] {
      PMC_FULL  = 5'h01,
      PMC_ENTER = 5'h02,
      PMC_QUIES = 5'h04,
      PMC_LOW   = 5'h08,
      PMC_WAKE  = 5'h10
   } pmc_state_t;

   typedef enum logic [1:0] {
      PMC_MODE_DOZE  = 2'h1,
      PMC_MODE_NAP   = 2'h2,
      PMC_MODE_SLEEP = 2'h3
   } pmc_mode_t;
endpackage

// ### design/pmc_sync3.sv
`timescale 1ns/10ps
// three-stage synchroniser; the output only moves when stages two and three agree
module pmc_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // elaboration check: a zero-width bus has nothing to synchronise
   if (W < 1) begin : g_bad_w
      $error("pmc_sync3: width must be at least one");
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         dout <= '0;
      end else if (ce) begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               dout[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// ### design/pmc_power_mode_controller.sv
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "pmc_defines.svh"
module pmc_power_mode_controller #(
   parameter int UNITS = 6,
   parameter int DEC_W = 32
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // execution unit demand from dispatch (same clock)
   input  wire logic [UNITS-1:0]  unit_busy,
   output logic      [UNITS-1:0]  unit_clk_en,
   // asynchronous wake sources from pins
   input  wire logic              ext_interrupt,
   input  wire logic              system_mgmt_interrupt,
   input  wire logic              perf_interrupt,
   input  wire logic              thermal_interrupt,
   // quiesce handshake, active low at the pins
   input  wire logic              quiesce_ack_n,
   output logic                   quiesce_request_n,
   // state to the core
   output logic                   snoop_enable,
   output logic                   dcache_enable,
   output logic                   dec_running,
   output logic                   core_clk_en,
   output logic                   smi_vector,
   output logic                   ext_vector,
   output logic                   dec_vector,
   output logic                   irq
);
   // elaboration checks: both widths must fit the 32-bit register port
   if (UNITS < 1 || UNITS > 32) begin : g_bad_units
      $error("pmc: UNITS must be 1..32");
   end
   if (DEC_W < 2 || DEC_W > 32) begin : g_bad_dec_w
      $error("pmc: DEC_W must be 2..32");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   // the ack is inverted ahead of the stages so every stage idles at zero after reset
   logic [4:0] pins_s;
   pmc_sync3 #(.W(5)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .din     ({~quiesce_ack_n, thermal_interrupt, perf_interrupt,
                 system_mgmt_interrupt, ext_interrupt}),
      .dout    (pins_s)
   );
   logic ext_s, smi_s, perf_s, therm_s, ack_s;
   assign ext_s   = pins_s[0];
   assign smi_s   = pins_s[1];
   assign perf_s  = pins_s[2];
   assign therm_s = pins_s[3];
   assign ack_s   = pins_s[4];

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0]            cfg_q;
   logic [`PMC_EV_W-1:0]   status_q;
   logic [`PMC_EV_W-1:0]   mask_q;
   logic [DEC_W-1:0]       dec_q;
   logic                   enter_req;
   logic                   dec_wr;
   pmc_pkg::pmc_state_t    state_q;
   pmc_pkg::pmc_mode_t     mode_q;
   logic                   dec_fire;
   logic                   reject;

   function automatic logic [2:0] mode_bits(input logic [31:0] c);
      mode_bits = {c[`PMC_BIT_SLEEP], c[`PMC_BIT_NAP], c[`PMC_BIT_DOZE]};
   endfunction

   function automatic logic one_hot3(input logic [2:0] b);
      one_hot3 = (b == 3'h1) || (b == 3'h2) || (b == 3'h4);
   endfunction

   // writing zero to the entry register is ignored
   assign enter_req = ce && reg_wr && (reg_addr == `PMC_ADDR_ENTER) && reg_wdata[`PMC_BIT_ENTER];
   assign dec_wr    = ce && reg_wr && (reg_addr == `PMC_ADDR_STATE);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_q <= `PMC_CFG_RESET;
         mask_q <= '0;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `PMC_ADDR_CFG: begin
               // only the mode and gating bits are stored; the rest read zero
               cfg_q <= reg_wdata & `PMC_CFG_WMASK;
            end
            `PMC_ADDR_MASK: begin
               mask_q <= reg_wdata[`PMC_EV_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decrementer: counts down, fires on reaching zero
   logic dec_tick;
   assign dec_tick = (state_q != pmc_pkg::PMC_LOW) || (mode_q != pmc_pkg::PMC_MODE_SLEEP);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dec_q    <= '0;
         dec_fire <= 1'b0;
      end else if (ce) begin
         dec_fire <= 1'b0;
         // a load wins over the count in the same cycle
         if (dec_wr) begin
            dec_q <= reg_wdata[DEC_W-1:0];
         end else if (dec_tick && dec_q != '0) begin
            dec_q <= dec_q - 1'b1;
            dec_fire <= (dec_q == {{(DEC_W-1){1'b0}}, 1'b1});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // event status: set wins over write-one-to-clear
   logic [`PMC_EV_W-1:0] ev_set;
   logic ext_d_q, smi_d_q, perf_d_q, therm_d_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ext_d_q <= 1'b0;
         smi_d_q <= 1'b0;
         perf_d_q <= 1'b0;
         therm_d_q <= 1'b0;
      end else if (ce) begin
         ext_d_q <= ext_s;
         smi_d_q <= smi_s;
         perf_d_q <= perf_s;
         therm_d_q <= therm_s;
      end
   end

   function automatic logic rise(input logic now_v, input logic before_v);
      rise = now_v & ~before_v;
   endfunction

   always_comb begin
      ev_set = '0;
      ev_set[`PMC_EV_EXT]    = rise(ext_s, ext_d_q);
      ev_set[`PMC_EV_SMI]    = rise(smi_s, smi_d_q);
      ev_set[`PMC_EV_DEC]    = dec_fire;
      ev_set[`PMC_EV_PERF]   = rise(perf_s, perf_d_q);
      ev_set[`PMC_EV_THERM]  = rise(therm_s, therm_d_q);
      ev_set[`PMC_EV_REJECT] = reject;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_q <= '0;
         irq      <= 1'b0;
      end else if (ce) begin
         if (reg_wr && reg_addr == `PMC_ADDR_STATUS) begin
            status_q <= (status_q & ~reg_wdata[`PMC_EV_W-1:0]) | ev_set;
         end else begin
            status_q <= status_q | ev_set;
         end
         // irq trails status by one cycle since it is a flip-flop itself
         irq <= |(status_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power state sequencer
   logic [2:0] mb;
   logic       wake;
   logic [3:0] ack_lo_cnt_q;
   logic [2:0] entry_cnt_q;
   assign mb = mode_bits(cfg_q);

   always_comb begin
      case (mode_q)
         pmc_pkg::PMC_MODE_SLEEP: wake = ext_s | smi_s | perf_s | therm_s;
         default: wake = ext_s | smi_s | perf_s | therm_s | dec_fire;
      endcase
   end

   assign reject = enter_req && state_q == pmc_pkg::PMC_FULL && !one_hot3(mb);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q     <= pmc_pkg::PMC_FULL;
         mode_q      <= pmc_pkg::PMC_MODE_DOZE;
         entry_cnt_q <= '0;
      end else if (ce) begin
         case (state_q)
            pmc_pkg::PMC_FULL: begin
               // only full power accepts an entry request
               if (enter_req && one_hot3(mb)) begin
                  mode_q <= mb[2] ? pmc_pkg::PMC_MODE_SLEEP :
                            mb[1] ? pmc_pkg::PMC_MODE_NAP : pmc_pkg::PMC_MODE_DOZE;
                  state_q <= pmc_pkg::PMC_ENTER;
                  entry_cnt_q <= 3'(`PMC_ENTRY_CYCLES);
               end
            end
            pmc_pkg::PMC_ENTER: begin
               // a wake level that is still held aborts the entry at once
               // the entry delay lets dispatched work drain before clocks stop
               if (wake) begin
                  state_q <= pmc_pkg::PMC_WAKE;
               end else if (entry_cnt_q != '0) begin
                  entry_cnt_q <= entry_cnt_q - 3'h1;
               end else if (mode_q == pmc_pkg::PMC_MODE_DOZE) begin
                  state_q <= pmc_pkg::PMC_LOW;
               end else begin
                  state_q <= pmc_pkg::PMC_QUIES;
               end
            end
            pmc_pkg::PMC_QUIES: begin
               // snooping stays on until the synchronised ack arrives
               if (wake) begin
                  state_q <= pmc_pkg::PMC_WAKE;
               end else if (ack_s) begin
                  state_q <= pmc_pkg::PMC_LOW;
               end
            end
            pmc_pkg::PMC_LOW: begin
               if (wake) begin
                  state_q <= pmc_pkg::PMC_WAKE;
               end
            end
            pmc_pkg::PMC_WAKE: begin
               state_q <= pmc_pkg::PMC_FULL;
            end
            default: begin
               state_q <= pmc_pkg::PMC_FULL;
            end
         endcase
      end
   end

   // nap snooping after the ack pin has been high (ack deasserted) long enough
   // the count saturates, so a long snoop window never wraps back to closed
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_lo_cnt_q <= '0;
      end else if (ce) begin
         if (ack_s) begin
            ack_lo_cnt_q <= '0;
         end else if (ack_lo_cnt_q != 4'(`PMC_SNOOP_CLOCKS)) begin
            ack_lo_cnt_q <= ack_lo_cnt_q + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all registered
   logic in_low, quies_st;
   assign in_low   = (state_q == pmc_pkg::PMC_LOW);
   assign quies_st = (state_q == pmc_pkg::PMC_QUIES) ||
                     (in_low && mode_q != pmc_pkg::PMC_MODE_DOZE);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         quiesce_request_n <= 1'b1;
         snoop_enable      <= 1'b1;
         dcache_enable     <= 1'b1;
         dec_running       <= 1'b1;
         core_clk_en       <= 1'b1;
         unit_clk_en       <= '1;
         smi_vector        <= 1'b0;
         ext_vector        <= 1'b0;
         dec_vector        <= 1'b0;
      end else if (ce) begin
         quiesce_request_n <= ~quies_st;
         case (1'b1)
            in_low && mode_q == pmc_pkg::PMC_MODE_NAP:
               snoop_enable <= (ack_lo_cnt_q == 4'(`PMC_SNOOP_CLOCKS));
            in_low && mode_q == pmc_pkg::PMC_MODE_SLEEP:
               snoop_enable <= 1'b0;
            default:
               snoop_enable <= (state_q != pmc_pkg::PMC_QUIES) || !ack_s;
         endcase
         // the cache stays off for the whole low state in every mode, doze included, even while snooping
         dcache_enable <= !in_low;
         dec_running   <= dec_tick;
         core_clk_en   <= !in_low;
         if (in_low) begin
            unit_clk_en <= '0;
         end else if (cfg_q[`PMC_BIT_GATE_EN]) begin
            // a busy unit gets its clock one cycle after busy is seen, since the enable is registered
            unit_clk_en <= unit_busy;
         end else begin
            unit_clk_en <= '1;
         end
         // vectors are one-cycle pulses on the event edge, not levels
         // separate vectors so the handler can pick a mode (external requests)
         smi_vector <= ev_set[`PMC_EV_SMI];
         ext_vector <= ev_set[`PMC_EV_EXT];
         dec_vector <= dec_fire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port: data one cycle after the read strobe
   // unmapped addresses read zero so software can probe the map
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               `PMC_ADDR_CFG:    reg_rdata <= cfg_q;
               `PMC_ADDR_STATUS: reg_rdata <= 32'(status_q);
               `PMC_ADDR_MASK:   reg_rdata <= 32'(mask_q);
               `PMC_ADDR_STATE:  reg_rdata <= 32'(dec_q);
               `PMC_ADDR_ENTER:  reg_rdata <= {25'h0, mode_q, state_q};
               default:          reg_rdata <= '0;
            endcase
         end
      end
   end
endmodule

// ### tb/pmc_power_mode_controller_assertions.sv
`timescale 1ns/10ps
module pmc_power_mode_controller_assertions #(
   parameter int UNITS = 6
) (
   input wire logic             clk_sys,
   input wire logic             rst,
   input wire logic [UNITS-1:0] unit_busy,
   input wire logic [UNITS-1:0] unit_clk_en,
   input wire logic             core_clk_en,
   input wire logic             snoop_enable,
   input wire logic             dec_running,
   input wire logic             quiesce_ack_n,
   input wire logic             quiesce_request_n,
   input wire logic             system_mgmt_interrupt,
   input wire logic             smi_vector,
   input wire logic             ext_interrupt,
   input wire logic             ext_vector,
   input wire logic             dec_vector
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   property p_busy_clocked;
      core_clk_en && $past(core_clk_en) |-> (unit_clk_en & $past(unit_busy)) == $past(unit_busy);
   endproperty
   a_busy_clocked: assert property (p_busy_clocked) else $error("busy unit not clocked");
   property p_low_units_off;
      !core_clk_en |-> unit_clk_en == '0;
   endproperty
   a_low_units_off: assert property (p_low_units_off) else $error("unit clock in low power");
   property p_ack_before_stop;
      $fell(snoop_enable) |-> $past(!quiesce_ack_n, 2);
   endproperty
   a_ack_before_stop: assert property (p_ack_before_stop) else $error("snoop off without ack");
   // request high for a while means doze, not the tail of a nap
   property p_doze_snoop;
      !core_clk_en && quiesce_request_n && $past(quiesce_request_n, 3) |-> snoop_enable;
   endproperty
   a_doze_snoop: assert property (p_doze_snoop) else $error("doze stopped snooping");
   property p_nap_window;
      $rose(snoop_enable) && !core_clk_en |-> $past(quiesce_ack_n, 8);
   endproperty
   a_nap_window: assert property (p_nap_window) else $error("snoop window opened early");
   property p_dec_stop;
      !dec_running |-> !core_clk_en && !snoop_enable;
   endproperty
   a_dec_stop: assert property (p_dec_stop) else $error("decrementer stopped outside sleep");
   property p_smi_vec;
      $rose(system_mgmt_interrupt) |-> ##[1:8] smi_vector;
   endproperty
   a_smi_vec: assert property (p_smi_vec) else $error("no management vector");
   property p_smi_pulse;
      smi_vector |=> !smi_vector;
   endproperty
   a_smi_pulse: assert property (p_smi_pulse) else $error("vector longer than a cycle");
   property p_wake_ext;
      !core_clk_en && ext_interrupt |-> ##[1:12] core_clk_en;
   endproperty
   a_wake_ext: assert property (p_wake_ext) else $error("no wake on interrupt");
   property p_ext_vec;
      $rose(ext_interrupt) |-> ##[1:8] ext_vector;
   endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("no external vector");
   property p_dec_wake;
      dec_vector && dec_running && !core_clk_en |-> ##[1:4] core_clk_en;
   endproperty
   a_dec_wake: assert property (p_dec_wake) else $error("no wake on decrementer");
endmodule
bind pmc_power_mode_controller pmc_power_mode_controller_assertions #(.UNITS(UNITS)) chk_u (
   .clk_sys, .rst, .unit_busy, .unit_clk_en, .core_clk_en, .snoop_enable, .dec_running,
   .quiesce_ack_n, .quiesce_request_n, .system_mgmt_interrupt, .smi_vector, .ext_interrupt,
   .ext_vector, .dec_vector);

// ### tb/pmc_system_model.sv
`timescale 1ns/10ps
// system logic facing the quiesce handshake
module pmc_system_model #(
   parameter int ACK_DELAY = 3
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic quiesce_request_n,
   input  wire logic snoop_req,
   output logic      quiesce_ack_n
);
   int wait_q;
   int snoop_q;
   // the delay stands in for outstanding bus work draining before the ack
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         quiesce_ack_n <= 1'b1;
         wait_q <= 0;
         snoop_q <= 0;
      end else if (quiesce_request_n) begin
         quiesce_ack_n <= 1'b1;
         wait_q <= 0;
         snoop_q <= 0;
      end else if (snoop_req) begin
         quiesce_ack_n <= 1'b1;
         snoop_q <= 20;
      end else if (snoop_q > 0) begin
         quiesce_ack_n <= (snoop_q > 1);
         snoop_q <= snoop_q - 1;
      end else if (wait_q < ACK_DELAY) begin
         wait_q <= wait_q + 1;
      end else begin
         quiesce_ack_n <= 1'b0;
      end
   end
endmodule

// ### tb/pmc_power_mode_controller_test.sv
`timescale 1ns/10ps
`include "pmc_defines.svh"
module pmc_power_mode_controller_test;
   logic        clk_sys, rst, ce, reg_wr, reg_rd, snoop_req;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv, dec_seen;
   logic [5:0]  unit_busy, unit_clk_en;
   logic        ext_interrupt, system_mgmt_interrupt, perf_interrupt, thermal_interrupt;
   logic        quiesce_ack_n, quiesce_request_n, snoop_enable, dcache_enable, dec_running;
   logic        core_clk_en, smi_vector, ext_vector, dec_vector, irq;
   int          n_fail, checks;
   logic [31:0] bad [3] = '{32'h0000_0000, 32'h0000_0300, 32'h0000_0700};
   logic [5:0]  ev [3] = '{6'h01, 6'h08, 6'h10};
   pmc_power_mode_controller dut_u (
      .clk_sys               (clk_sys),
      .rst                   (rst),
      .ce                    (ce),
      .reg_addr              (reg_addr),
      .reg_wdata             (reg_wdata),
      .reg_wr                (reg_wr),
      .reg_rd                (reg_rd),
      .reg_rdata             (reg_rdata),
      .unit_busy             (unit_busy),
      .unit_clk_en           (unit_clk_en),
      .ext_interrupt         (ext_interrupt),
      .system_mgmt_interrupt (system_mgmt_interrupt),
      .perf_interrupt        (perf_interrupt),
      .thermal_interrupt     (thermal_interrupt),
      .quiesce_ack_n         (quiesce_ack_n),
      .quiesce_request_n     (quiesce_request_n),
      .snoop_enable          (snoop_enable),
      .dcache_enable         (dcache_enable),
      .dec_running           (dec_running),
      .core_clk_en           (core_clk_en),
      .smi_vector            (smi_vector),
      .ext_vector            (ext_vector),
      .dec_vector            (dec_vector),
      .irq                   (irq)
   );
   pmc_system_model #(.ACK_DELAY(3)) sys_u (.clk_sys, .rst, .quiesce_request_n, .snoop_req,
      .quiesce_ack_n);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic enter(input logic [31:0] cfg);
      wr(`PMC_ADDR_CFG, cfg);
      wr(`PMC_ADDR_ENTER, 32'h0000_0001);
   endtask
   // polls the state readback with a bounded count, then compares
   task automatic wait_st(input logic [4:0] s);
      for (int i = 0; i < 200; i++) begin
         rd(`PMC_ADDR_ENTER);
         if (rv[4:0] === s) break;
      end
      chk(rv[4:0], s);
   endtask
   task automatic wake(input int k, input logic v);
      @(posedge clk_sys);
      case (k)
         0: ext_interrupt <= v;
         1: perf_interrupt <= v;
         default: thermal_interrupt <= v;
      endcase
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata, unit_busy, snoop_req} = '0;
      {ext_interrupt, system_mgmt_interrupt, perf_interrupt, thermal_interrupt} = 4'h0;
      ce = 1'b1;
      rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1 chk({core_clk_en, quiesce_request_n, unit_clk_en}, 8'hFF);
      rd(`PMC_ADDR_CFG);
      chk(rv, 32'h0000_0000);
      wr(`PMC_ADDR_CFG, 32'hFFFF_FFFF);
      rd(`PMC_ADDR_CFG);
      chk(rv, 32'h0000_0F00);
      wr(4'hF, 32'h0000_0001);
      rd(4'hF);
      chk(rv, 32'h0000_0000);
      wr(`PMC_ADDR_CFG, 32'h0000_0800);
      unit_busy <= 6'h05;
      repeat (3) @(posedge clk_sys);
      #1 chk(unit_clk_en, 6'h05);
      wr(`PMC_ADDR_CFG, 32'h0000_0000);
      repeat (3) @(posedge clk_sys);
      #1 chk(unit_clk_en, 6'h3F);
      // clock enable low freezes the decrementer: one count after it returns
      wr(`PMC_ADDR_STATE, 32'h0000_0032);
      ce <= 1'b0;
      repeat (20) @(posedge clk_sys);
      ce <= 1'b1;
      rd(`PMC_ADDR_STATE);
      chk(rv, 32'h0000_0031);
      wr(`PMC_ADDR_STATE, 32'h0000_0000);
      wr(`PMC_ADDR_MASK, 32'h0000_003F);
      foreach (bad[i]) begin
         enter(bad[i]);
         rd(`PMC_ADDR_STATUS);
         chk(rv[5], 1'b1);
         rd(`PMC_ADDR_ENTER);
         chk(rv[4:0], pmc_pkg::PMC_FULL);
         wr(`PMC_ADDR_STATUS, 32'h0000_003F);
      end
      repeat (2) @(posedge clk_sys);
      #1 chk(irq, 1'b0);
      for (int k = 0; k < 3; k++) begin
         enter(32'h0000_0100);
         wait_st(pmc_pkg::PMC_LOW);
         chk({snoop_enable, dec_running, quiesce_request_n, dcache_enable}, 4'hE);
         enter(32'h0000_0400);
         rd(`PMC_ADDR_ENTER);
         chk(rv[4:0], pmc_pkg::PMC_LOW);
         wake(k, 1'b1);
         wait_st(pmc_pkg::PMC_FULL);
         wake(k, 1'b0);
         rd(`PMC_ADDR_STATUS);
         chk(rv[5:0], ev[k]);
         chk(irq, 1'b1);
         wr(`PMC_ADDR_STATUS, 32'h0000_003F);
      end
      wr(`PMC_ADDR_STATE, 32'h0000_012C);
      enter(32'h0000_0200);
      wait_st(pmc_pkg::PMC_LOW);
      chk({snoop_enable, dec_running, quiesce_request_n, core_clk_en}, 4'h4);
      @(posedge clk_sys);
      snoop_req <= 1'b1;
      @(posedge clk_sys);
      snoop_req <= 1'b0;
      repeat (16) @(posedge clk_sys);
      #1 chk(snoop_enable, 1'b1);
      repeat (12) @(posedge clk_sys);
      #1 chk(snoop_enable, 1'b0);
      wait_st(pmc_pkg::PMC_FULL);
      rd(`PMC_ADDR_STATUS);
      chk(rv[2], 1'b1);
      wr(`PMC_ADDR_STATUS, 32'h0000_003F);
      // decrementer left short of zero must hold its count through sleep
      wr(`PMC_ADDR_STATE, 32'h0000_003C);
      enter(32'h0000_0400);
      wait_st(pmc_pkg::PMC_LOW);
      chk({snoop_enable, dec_running, core_clk_en}, 3'h0);
      rd(`PMC_ADDR_STATE);
      dec_seen = rv;
      repeat (80) @(posedge clk_sys);
      rd(`PMC_ADDR_STATE);
      chk(rv, dec_seen);
      rd(`PMC_ADDR_ENTER);
      chk(rv[4:0], pmc_pkg::PMC_LOW);
      wake(1, 1'b1);
      wait_st(pmc_pkg::PMC_FULL);
      wake(1, 1'b0);
      wr(`PMC_ADDR_STATUS, 32'h0000_003F);
      system_mgmt_interrupt <= 1'b1;
      repeat (8) @(posedge clk_sys);
      system_mgmt_interrupt <= 1'b0;
      rd(`PMC_ADDR_STATUS);
      chk(rv[1], 1'b1);
      tally_and_finish;
   end
endmodule
